// ---- pkg/dsp_seq_consts.vh ----
// Constants for the display readout sequencer: bus map, field positions,
// sequencer state codes and reset values.
// Assumes a single 20 MHz clock and an AHB-Lite master with word access only.
`ifndef DSP_SEQ_CONSTS_VH
`define DSP_SEQ_CONSTS_VH

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MARKER      8'h08
`define REG_DOT         8'h0C

`define CTRL_RUN_BIT    0
`define CTRL_TRC_LSB    1
`define CTRL_RESET      3'h0

`define RAM_WORDS       512
`define ALPHA_LSB       0
`define FIFO_DEPTH      32
`define DOT_WIDTH       9

`define ST_WAIT         5'h00
`define ST_STEP         5'h01
`define ST_NEXT         5'h02
`define ST_F0           5'h04
`define ST_F1           5'h05
`define ST_F2           5'h06
`define ST_F3           5'h07
`define ST_IDLE         5'h08
`define ST_DOT          5'h10
`define ST_CHK          5'h18
`define ST_RESET        5'h08

`endif

// ---- logic/display_readout_sequencer.v ----
// Display readout sequencer with its dot FIFO and AHB-Lite register slave.
// Assumes the shared RAM answers within the fetch cycle and that the
// processor holds off its own RAM cycles while o_fetch_n is low.
`include "dsp_seq_consts.vh"
`default_nettype none

module dot_fifo #(
    parameter W  = 9,
    parameter D  = 32,
    parameter AW = 5
) (
    input  wire          i_clk,
    input  wire          i_arst_n,
    input  wire          i_in_valid,
    output wire          o_in_ready,
    input  wire [W-1:0]  i_in_data,
    output wire          o_out_valid,
    input  wire          i_out_ready,
    output wire [W-1:0]  o_out_data
);
    localparam [AW:0] FULL_COUNT = D;

    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0]   count_r;
    wire         push;
    wire         pop;

    assign o_in_ready  = (count_r != FULL_COUNT);
    assign o_out_valid = (count_r != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr_r];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = i_out_ready & o_out_valid;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // dot_fifo

module display_readout_sequencer (
    input  wire        i_clk,
    input  wire        i_arst_n,
    input  wire        i_hsel,
    input  wire [7:0]  i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    output reg         o_fetch_n,
    output reg  [8:0]  o_ram_addr,
    input  wire [15:0] i_ram_data,
    input  wire        i_marker_n,
    output reg         o_dot_step_n,
    output reg         o_eoc_n,
    output reg  [4:0]  o_char_x,
    output reg  [1:0]  o_char_y,
    output reg  [1:0]  o_trace_count
);
    reg  [4:0]  state_r;
    reg  [4:0]  state_nxt;
    reg         qual;
    reg  [9:1]  addr_r;
    reg         wrap_r;
    reg  [15:0] data_r;
    reg  [2:0]  load_pipe_r;
    reg  [2:0]  load_n_r;
    reg  [11:0] char_cnt_r;
    reg  [8:0]  pattern_r;
    reg         pattern_last_r;
    reg  [2:0]  ctrl_r;
    reg  [4:0]  marker_r;
    reg         wr_pend_r;
    reg  [7:0]  wr_addr_r;
    reg  [31:0] rdata_nxt;
    reg         dec_fetch;
    reg  [2:0]  dec_load;
    reg         dec_step;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [8:0]  fifo_out_data;
    wire        fifo_pop;
    wire        rd_take;
    wire        wr_take;
    wire [3:0]  alpha;
    wire [9:0]  pattern_word;

    // Pattern table: dot index in the low nibble, last dot at index F
    function [9:0] pattern_rom;
        input [11:0] a;
        begin
            pattern_rom = {(a[3:0] == 4'hF),
                           1'b0, a[1:0] ^ a[5:4], a[9], a[11],
                           a[3:2] ^ a[7:6], a[8], a[10]};
        end
    endfunction

    // Sequencer table indexed by {state, qualifier}
    function [4:0] seq_rom;
        input [5:0] a;
        begin
            case (a)
                {`ST_IDLE, 1'b1}: seq_rom = `ST_F0;
                {`ST_IDLE, 1'b0}: seq_rom = `ST_IDLE;
                {`ST_F0, 1'b0},
                {`ST_F0, 1'b1}:   seq_rom = `ST_F1;
                {`ST_F1, 1'b0},
                {`ST_F1, 1'b1}:   seq_rom = `ST_F2;
                {`ST_F2, 1'b0},
                {`ST_F2, 1'b1}:   seq_rom = `ST_F3;
                {`ST_F3, 1'b0},
                {`ST_F3, 1'b1}:   seq_rom = `ST_DOT;
                {`ST_DOT, 1'b1}:  seq_rom = `ST_STEP;
                {`ST_DOT, 1'b0}:  seq_rom = `ST_DOT;
                {`ST_STEP, 1'b0},
                {`ST_STEP, 1'b1}: seq_rom = `ST_WAIT;
                {`ST_WAIT, 1'b0},
                {`ST_WAIT, 1'b1}: seq_rom = `ST_CHK;
                {`ST_CHK, 1'b1}:  seq_rom = `ST_NEXT;
                {`ST_CHK, 1'b0}:  seq_rom = `ST_DOT;
                {`ST_NEXT, 1'b1}: seq_rom = `ST_IDLE;
                {`ST_NEXT, 1'b0}: seq_rom = `ST_F0;
                default:          seq_rom = `ST_IDLE;
            endcase
        end
    endfunction

    // Qualifier selected by the state code's top field
    always @* begin
        case (state_r[4:3])
            2'b00:   qual = wrap_r;
            2'b01:   qual = ctrl_r[`CTRL_RUN_BIT];
            2'b10:   qual = fifo_in_ready;
            2'b11:   qual = ~o_eoc_n;
            default: qual = 1'b0;
        endcase
        state_nxt = seq_rom({state_r, qual});
    end

    // Instruction decoders enabled by a zero top field; the middle bit picks fetch or step
    always @* begin
        dec_fetch = 1'b0;
        dec_load  = 3'b000;
        dec_step  = 1'b0;
        if (state_r[4:3] == 2'b00) begin
            if (state_r[2]) begin
                dec_fetch = 1'b1;
                case (state_r[1:0])
                    2'b00:   dec_load = 3'b001;
                    2'b01:   dec_load = 3'b010;
                    2'b10:   dec_load = 3'b100;
                    default: dec_load = 3'b000;
                endcase
            end else begin
                dec_step = (state_r[1:0] == 2'b01);
            end
        end
    end

    assign alpha        = data_r[`ALPHA_LSB +: 4];
    assign pattern_word = pattern_rom(char_cnt_r);

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r      <= `ST_RESET;
            o_fetch_n    <= 1'b1;
            load_pipe_r  <= 3'b000;
            load_n_r     <= 3'b111;
            o_dot_step_n <= 1'b1;
        end else begin
            state_r      <= state_nxt;
            o_fetch_n    <= ~dec_fetch;
            load_pipe_r  <= dec_load;
            load_n_r     <= ~load_pipe_r;
            o_dot_step_n <= ~dec_step;
        end
    end

    // Address counter walks all 512 words, so every RAM row is read
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_r     <= 9'h000;
            wrap_r     <= 1'b0;
            data_r     <= 16'h0000;
            o_ram_addr <= 9'h000;
            o_char_x   <= 5'h00;
            o_char_y   <= 2'h0;
        end else begin
            if (!o_fetch_n) begin
                data_r <= i_ram_data;
                addr_r <= addr_r + 9'h001;
                wrap_r <= (addr_r == 9'h1FF);
            end
            o_ram_addr <= (!o_fetch_n) ? (addr_r + 9'h001) : addr_r;
            o_char_x   <= addr_r[7:3];
            o_char_y   <= addr_r[9:8];
        end
    end

    // Character counter: three nibble presets, then dot stepping
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            char_cnt_r     <= 12'h000;
            pattern_r      <= 9'h000;
            pattern_last_r <= 1'b0;
            o_eoc_n        <= 1'b1;
        end else begin
            if (!load_n_r[0]) begin
                char_cnt_r[11:8] <= alpha;
            end
            if (!load_n_r[1]) begin
                char_cnt_r[7:4] <= alpha;
            end
            if (!load_n_r[2]) begin
                char_cnt_r[3:0] <= alpha;
                o_eoc_n         <= 1'b1;
            end
            if (!o_dot_step_n) begin
                char_cnt_r     <= char_cnt_r + 12'h001;
                pattern_r      <= pattern_word[8:0];
                pattern_last_r <= pattern_word[9];
                o_eoc_n        <= ~pattern_word[9];
            end
        end
    end

    dot_fifo #(
        .W  (`DOT_WIDTH),
        .D  (`FIFO_DEPTH),
        .AW (5)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (~o_dot_step_n),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (pattern_word[8:0]),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_data)
    );

    // AHB-Lite slave: zero wait states, OKAY always
    assign rd_take  = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
    assign wr_take  = i_hsel & i_htrans[1] & i_hready & i_hwrite;
    assign fifo_pop = rd_take & (i_haddr == `REG_DOT);

    always @* begin
        case (i_haddr)
            `REG_CTRL:   rdata_nxt = {29'h0, ctrl_r};
            `REG_STATUS: rdata_nxt = {12'h000, addr_r, 2'h0, pattern_last_r,
                                      ~o_eoc_n, fifo_in_ready, fifo_out_valid,
                                      state_r};
            `REG_MARKER: rdata_nxt = {27'h0, marker_r};
            `REG_DOT:    rdata_nxt = {22'h0, fifo_out_valid, fifo_out_data};
            default:     rdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata      <= 32'h0000_0000;
            o_hreadyout   <= 1'b1;
            o_hresp       <= 1'b0;
            wr_pend_r     <= 1'b0;
            wr_addr_r     <= 8'h00;
            ctrl_r        <= `CTRL_RESET;
            marker_r      <= 5'h00;
            o_trace_count <= 2'h0;
        end else begin
            o_hreadyout   <= 1'b1;
            o_hresp       <= 1'b0;
            wr_pend_r     <= wr_take;
            if (wr_take) begin
                wr_addr_r <= i_haddr;
            end
            if (rd_take) begin
                o_hrdata <= rdata_nxt;
            end
            if (wr_pend_r && wr_addr_r == `REG_CTRL) begin
                ctrl_r <= i_hwdata[2:0];
            end
            o_trace_count <= ctrl_r[`CTRL_TRC_LSB +: 2];
            if (!i_marker_n) begin
                marker_r <= addr_r[7:3];
            end
        end
    end
endmodule // display_readout_sequencer

`default_nettype wire

// ---- sim/ram_partner.sv ----
// Model of the shared display RAM and of the processor that yields to it.
// Assumes the sequencer samples data at the edge ending each fetch cycle.
`default_nettype none
module ram_partner (
    input  wire logic        i_clk,
    input  wire logic        i_fetch_n,
    input  wire logic [8:0]  i_addr,
    output logic      [15:0] o_data,
    output logic             o_cpu_defer,
    output logic             o_seen_all
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0]  last_r = 16'h0000;
    logic [511:0] seen_r = '0;
    assign o_cpu_defer = !i_fetch_n;
    assign o_seen_all  = &seen_r;
    // Third word of a character presets the last dot; released bus shows junk
    always_comb begin
        if (!i_fetch_n) begin
            o_data = {3'h0, i_addr, (i_addr[1:0] == 2'h2) ? 4'hF : 4'h0};
        end else begin
            o_data = ~last_r;
        end
    end
    always @(posedge i_clk) begin
        if (!i_fetch_n) begin
            last_r         <= o_data;
            seen_r[i_addr] <= 1'b1;
        end
    end
endmodule // ram_partner
`default_nettype wire

// ---- sim/seq_checker.sv ----
// Port checker for the display readout sequencer, bound to its top module.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none
module seq_checker (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_hsel,
    input wire logic [7:0]  i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic        o_fetch_n,
    input wire logic [8:0]  o_ram_addr,
    input wire logic        o_dot_step_n,
    input wire logic        o_eoc_n,
    input wire logic [4:0]  o_char_x,
    input wire logic [1:0]  o_char_y,
    input wire logic [1:0]  o_trace_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_ctrl_r;
    logic run_r;
    // Tracks control writes so run state is known
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ctrl_r <= 1'b0;
            run_r     <= 1'b0;
        end else begin
            wr_ctrl_r <= i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr == 8'h00;
            if (wr_ctrl_r)
                run_r <= i_hwdata[0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_fetch_addr_step: assert property (!o_fetch_n && $past(!o_fetch_n) |->
        o_ram_addr == $past(o_ram_addr) + 9'h001) else $error("fetch address not stepped");
    a_fetch_four_words: assert property ($fell(o_fetch_n) |->
        !o_fetch_n [*4] ##1 o_fetch_n) else $error("fetch burst not four words");
    a_step_one_cycle: assert property ($fell(o_dot_step_n) |=>
        o_dot_step_n) else $error("dot step too long");
    a_char_position: assert property (!o_fetch_n && $past(!o_fetch_n) |->
        o_char_x == o_ram_addr[6:2] && o_char_y == o_ram_addr[8:7]) else $error("bad position");
    a_eoc_with_step: assert property ($fell(o_eoc_n) |->
        !o_dot_step_n || $past(!o_dot_step_n)) else $error("end of char without dot");
    a_eoc_then_fetch: assert property ($fell(o_eoc_n) && run_r |->
        ##[1:40] !o_fetch_n) else $error("no fetch after end of char");
    a_one_command: assert property (!(!o_fetch_n && !o_dot_step_n))
        else $error("fetch and dot step together");
    a_trace_ctrl: assert property (wr_ctrl_r |-> ##2
        o_trace_count == $past(i_hwdata[2:1], 2)) else $error("trace count not taken");
    a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus not ready or okay");
endmodule // seq_checker
bind display_readout_sequencer seq_checker seq_checker_inst (.i_clk, .i_arst_n, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_fetch_n,
    .o_ram_addr, .o_dot_step_n, .o_eoc_n, .o_char_x, .o_char_y, .o_trace_count);
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench for the display readout sequencer: bus tasks and scenarios.
// Assumes the RAM partner answers each fetch in the same cycle.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        marker_n = 1'b1;
    logic [31:0] hrdata, q;
    logic        hready, fetch_n, eoc_n, seen_all;
    logic [8:0]  ram_addr;
    logic [15:0] ram_data;
    logic [1:0]  trace_count;
    int          fails = 0;
    int          n_checks = 0;
    int          pops;
    logic        done;
    always #25 clk = ~clk;
    display_readout_sequencer display_readout_sequencer_inst (.i_clk(clk), .i_arst_n(arst_n),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(), .o_fetch_n(fetch_n), .o_ram_addr(ram_addr), .i_ram_data(ram_data),
        .i_marker_n(marker_n), .o_dot_step_n(), .o_eoc_n(eoc_n), .o_char_x(), .o_char_y(),
        .o_trace_count(trace_count));
    ram_partner ram_partner_inst (.i_clk(clk), .i_fetch_n(fetch_n), .i_addr(ram_addr),
        .o_data(ram_data), .o_cpu_defer(), .o_seen_all(seen_all));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        chk("reset pins", 32'h1800, {19'h0, fetch_n, eoc_n, trace_count, ram_addr});
        bus(1'b0, 8'h04, 32'h0);
        chk("status", 32'h48, q & 32'hFFFFFE7F);
        bus(1'b1, 8'h00, 32'h4);
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h4, q);
        chk("traces", 32'h2, {30'h0, trace_count});
        bus(1'b1, 8'h04, 32'hFFFF);
        bus(1'b0, 8'h04, 32'h0);
        chk("status ro", 32'h48, q & 32'hFFFFFE7F);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        @(posedge clk);
        marker_n <= 1'b0;
        repeat (3) @(posedge clk);
        marker_n <= 1'b1;
        bus(1'b0, 8'h08, 32'h0);
        chk("marker", 32'h0, q);
        bus(1'b1, 8'h00, 32'h5);
        repeat (2000) @(posedge clk);
        bus(1'b0, 8'h04, 32'h0);
        chk("fifo full", 32'h20, q & 32'h60);
        bus(1'b1, 8'h00, 32'h4);
        pops = 0;
        done = 1'b0;
        for (int i = 0; i < 3000 && !done; i++) begin
            bus(1'b0, 8'h0C, 32'h0);
            if (q[9] === 1'b1)
                pops++;
            bus(1'b0, 8'h04, 32'h0);
            done = q[4:0] === 5'h08 && q[5] === 1'b0;
        end
        chk("dots", 32'd128, pops);
        chk("counter", 32'h0, {23'h0, q[19:11]});
        chk("refresh", 32'h1, {31'h0, seen_all});
        conclude();
    end
endmodule // tb
`default_nettype wire
